// ===== core/odts_divider.sv
// Behaviour
// - Divide the oscillator into octave clocks, lowest band 1.53-3.05 kHz.
// - First two stages each halve; each stage output is also a mux tap.
// - A three-stage counter on the 50-100 MHz stage yields 6-12 MHz.
// - A twelve-stage counter on 6-12 MHz makes all lower octaves.
// - Tap selects decode combinationally from four code bits and harmonic mode.
// - Octave code bit three is the MSB; valid codes run 2 to 14.
// - Each code picks one detection octave, 25 kHz up to 200 MHz.
// - Detection equals reference normally, twice reference in harmonic mode.
// - Two cascaded muxes deliver the detection-frequency clock.
// - Reference tap retimed twice on twice-reference clock: loop and output.
// - Twice-reference from two muxes, one enabled, outputs ORed.
// - TTL reference output only for codes 2-7; off when MSB high.
// - Enabled TTL reference is a complementary true/inverse pair.
// - Fixed taps: 6-12 MHz chop sync, 24-49 kHz and 49-98 kHz.
// - The 49-98 kHz fixed tap is the data sampling clock.
// - Mux select fields: bit 0 LSB, bit 2 MSB, bit 3 gate.
`timescale 1ns/100ps
module odts_divider
  import odts_pkg::*;
#(
  parameter int CHAIN_W = ODTS_CHAIN_W
) (
  // Clock and reset; clock samples at twice the oscillator rate
  input wire logic clock,
  input wire logic rstn,
  // Octave code and mode from range-select logic
  input wire logic octave_code_msb,
  input wire logic octave_code_b1,
  input wire logic octave_code_b2,
  input wire logic octave_code_lsb,
  input wire logic harmonic_detect_select,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ODTS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Selected clocks
  output logic det_clk,
  output logic twice_ref_clk,
  output logic ref_loop,
  output logic ref_out,
  // TTL reference pair
  output logic ttl_ref_p,
  output logic ttl_ref_n,
  // Fixed taps
  output logic chop_sync_clk,
  output logic fixed_24k_clk,
  output logic sample_clk
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [4:0] odts_exp(input logic [3:0] code, input logic [1:0] add);
    odts_exp = ODTS_EXP_BASE - {1'b0, code} + {3'h0, add};
  endfunction : odts_exp

  // Cascade: upper mux takes chain bits 0..7, lower takes 8..14 plus upper output
  function automatic logic [7:0] odts_cascade(input logic [4:0] e, input logic ok);
    logic [4:0] low;
    low = e - ODTS_EXP_SPLIT;
    if (!ok) begin
      odts_cascade = {ODTS_SEL_OFF, ODTS_SEL_OFF};
    end else if (e < ODTS_EXP_SPLIT) begin
      odts_cascade = {1'b1, e[2:0], 1'b1, ODTS_SEL_CHAIN};
    end else begin
      odts_cascade = {ODTS_SEL_OFF, 1'b1, low[2:0]};
    end
  endfunction : odts_cascade

  // Split: one of two muxes is gated on, the other held low
  function automatic logic [7:0] odts_split(input logic [4:0] e, input logic ok);
    logic [4:0] low;
    low = e - ODTS_EXP_SPLIT;
    if (!ok) begin
      odts_split = {ODTS_SEL_OFF, ODTS_SEL_OFF};
    end else if (e < ODTS_EXP_SPLIT) begin
      odts_split = {1'b1, e[2:0], ODTS_SEL_OFF};
    end else begin
      odts_split = {ODTS_SEL_OFF, 1'b1, low[2:0]};
    end
  endfunction : odts_split

  ////////////////////////////////////////////////////////////////////////////
  // Tap select decode

  logic [3:0] code;
  logic code_ok;
  logic [4:0] exp_det;
  logic [4:0] exp_ref;
  logic [4:0] exp_twice;
  logic [7:0] sel_det;
  logic [7:0] sel_ref;
  logic [7:0] sel_twice;
  logic ttl_en;
  logic ttl_allow;
  logic div_clear;

  always_comb begin
    code = {octave_code_msb, octave_code_b1, octave_code_b2, octave_code_lsb};
    code_ok = (code >= ODTS_CODE_MIN) && (code <= ODTS_CODE_MAX);
    exp_det = odts_exp(code, ODTS_ADD_DET);
    exp_ref = harmonic_detect_select ? odts_exp(code, ODTS_ADD_REF + ODTS_ADD_2F)
                                     : odts_exp(code, ODTS_ADD_REF);
    exp_twice = harmonic_detect_select ? odts_exp(code, ODTS_ADD_TWICE + ODTS_ADD_2F)
                                       : odts_exp(code, ODTS_ADD_TWICE);
    sel_det = odts_cascade(exp_det, code_ok);
    sel_ref = odts_cascade(exp_ref, code_ok);
    sel_twice = odts_split(exp_twice, code_ok);
    ttl_en = !octave_code_msb && code_ok && ttl_allow;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider chain

  logic [CHAIN_W-1:0] chain;
  logic [CHAIN_W-1:0] next_chain;

  // One synchronous counter; every bit is one halving stage, so all taps share an edge
  always_comb begin
    next_chain = div_clear ? '0 : chain + {{(CHAIN_W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      chain <= '0;
    end else begin
      chain <= next_chain;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tap multiplexers

  logic det_hi;
  logic det_lo;
  logic ref_hi;
  logic ref_lo;
  logic twice_hi;
  logic twice_lo;

  odts_tap_mux u_det_hi (.clock(clock), .rstn(rstn), .clear(div_clear),
    .taps(chain[7:0]), .sel_field(sel_det[7:4]), .tap_out(det_hi));
  odts_tap_mux u_det_lo (.clock(clock), .rstn(rstn), .clear(div_clear),
    .taps({det_hi, chain[14:8]}), .sel_field(sel_det[3:0]), .tap_out(det_lo));
  odts_tap_mux u_ref_hi (.clock(clock), .rstn(rstn), .clear(div_clear),
    .taps(chain[7:0]), .sel_field(sel_ref[7:4]), .tap_out(ref_hi));
  odts_tap_mux u_ref_lo (.clock(clock), .rstn(rstn), .clear(div_clear),
    .taps({ref_hi, chain[14:8]}), .sel_field(sel_ref[3:0]), .tap_out(ref_lo));
  odts_tap_mux u_twice_hi (.clock(clock), .rstn(rstn), .clear(div_clear),
    .taps(chain[7:0]), .sel_field(sel_twice[7:4]), .tap_out(twice_hi));
  odts_tap_mux u_twice_lo (.clock(clock), .rstn(rstn), .clear(div_clear),
    .taps(chain[15:8]), .sel_field(sel_twice[3:0]), .tap_out(twice_lo));

  ////////////////////////////////////////////////////////////////////////////
  // Retiming and outputs

  logic twice_prev;
  logic twice_rise;
  logic next_det_clk;
  logic next_twice_ref_clk;
  logic next_twice_prev;
  logic next_ref_loop;
  logic next_ref_out;
  logic next_ttl_ref_p;
  logic next_ttl_ref_n;
  logic next_chop_sync_clk;
  logic next_fixed_24k_clk;
  logic next_sample_clk;

  // Retiming flops load on the rising twice-reference edge, seen one cycle late
  assign twice_rise = twice_ref_clk && !twice_prev;

  always_comb begin
    next_det_clk = div_clear ? 1'b0 : det_lo;
    next_twice_ref_clk = div_clear ? 1'b0 : (twice_hi | twice_lo);
    next_twice_prev = div_clear ? 1'b0 : twice_ref_clk;
    next_ref_loop = ref_loop;
    next_ref_out = ref_out;
    if (div_clear) begin
      next_ref_loop = 1'b0;
      next_ref_out = 1'b0;
    end else if (twice_rise) begin
      next_ref_loop = ref_lo;
      next_ref_out = ref_lo;
    end
    next_ttl_ref_p = ttl_en ? ref_out : 1'b0;
    next_ttl_ref_n = ttl_en ? !ref_out : 1'b0;
    next_chop_sync_clk = chain[ODTS_BIT_CHOP];
    next_fixed_24k_clk = chain[ODTS_BIT_FIX24K];
    next_sample_clk = chain[ODTS_BIT_SAMPLE];
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      det_clk <= 1'b0;
      twice_ref_clk <= 1'b0;
      twice_prev <= 1'b0;
      ref_loop <= 1'b0;
      ref_out <= 1'b0;
      ttl_ref_p <= 1'b0;
      ttl_ref_n <= 1'b0;
      chop_sync_clk <= 1'b0;
      fixed_24k_clk <= 1'b0;
      sample_clk <= 1'b0;
    end else begin
      det_clk <= next_det_clk;
      twice_ref_clk <= next_twice_ref_clk;
      twice_prev <= next_twice_prev;
      ref_loop <= next_ref_loop;
      ref_out <= next_ref_out;
      ttl_ref_p <= next_ttl_ref_p;
      ttl_ref_n <= next_ttl_ref_n;
      chop_sync_clk <= next_chop_sync_clk;
      fixed_24k_clk <= next_fixed_24k_clk;
      sample_clk <= next_sample_clk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait-free access phase

  logic setup;
  logic wr_done;
  logic mapped;
  logic next_ttl_allow;
  logic next_div_clear;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic [31:0] status;

  assign setup = psel && !penable;
  assign wr_done = psel && penable && pready && pwrite;
  assign mapped = (paddr == ODTS_ADDR_CTRL) || (paddr == ODTS_ADDR_STATUS)
                  || (paddr == ODTS_ADDR_COUNT);

  always_comb begin
    status = 32'h0;
    status[ODTS_ST_CODE +: 4] = code;
    status[ODTS_ST_MODE] = harmonic_detect_select;
    status[ODTS_ST_VALID] = code_ok;
    status[ODTS_ST_TTL] = ttl_en;
    status[ODTS_ST_REF] = ref_loop;
    status[ODTS_ST_TWICE] = twice_ref_clk;
    status[ODTS_ST_DET] = det_clk;
    next_pready = setup;
    next_pslverr = setup && !mapped;
    next_prdata = prdata;
    if (setup) begin
      case (paddr)
        ODTS_ADDR_CTRL: next_prdata = {31'h0, ttl_allow};
        ODTS_ADDR_STATUS: next_prdata = status;
        ODTS_ADDR_COUNT: next_prdata = {{(32-CHAIN_W){1'b0}}, chain};
        default: next_prdata = 32'h0;
      endcase
    end
    next_ttl_allow = ttl_allow;
    // Clear is a one-cycle pulse; the bit always reads back zero
    next_div_clear = 1'b0;
    if (wr_done && (paddr == ODTS_ADDR_CTRL) && pstrb[0]) begin
      next_ttl_allow = pwdata[ODTS_CTRL_TTL_ALLOW];
      next_div_clear = pwdata[ODTS_CTRL_DIV_CLEAR];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      ttl_allow <= ODTS_CTRL_TTL_RESET;
      div_clear <= 1'b0;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      ttl_allow <= next_ttl_allow;
      div_clear <= next_div_clear;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_stage_halves: assert property (!div_clear && chain[0] |=> chain[1] != $past(chain[1]))
    else $error("second stage did not halve the first");
  a_div8_tap: assert property (##1 chop_sync_clk == $past(chain[ODTS_BIT_DIV8]))
    else $error("chop sync is not the divide-by-eight stage");
  a_ripple_last: assert property (!div_clear && (chain[ODTS_BIT_LAST-1:0] != '1)
                   |=> $stable(chain[ODTS_BIT_LAST]))
    else $error("last stage moved without carry");
  a_sample_tap: assert property (##1 sample_clk == $past(chain[ODTS_BIT_SAMPLE]))
    else $error("sampling clock is not the fixed tap");
  a_fixed_24k: assert property (##1 fixed_24k_clk == $past(chain[ODTS_BIT_FIX24K]))
    else $error("fixed low tap wrong");
  a_harm_double: assert property (code_ok |->
                   (harmonic_detect_select ? exp_ref == exp_det + 5'h01 : exp_ref == exp_det))
    else $error("reference exponent does not match detection");
  a_det_octave: assert property (code_ok |-> exp_det == 5'h0f - {1'b0, code})
    else $error("detection octave decode wrong");
  a_twice_onehot: assert property (!(sel_twice[7] && sel_twice[3]))
    else $error("both twice-reference muxes enabled");
  a_retime_edge: assert property (!$past(div_clear) && $changed(ref_loop) |-> $past(twice_rise))
    else $error("reference retimed off the twice edge");
  a_retime_pair: assert property (ref_loop == ref_out)
    else $error("retimed copies differ");
  a_ttl_gated: assert property (octave_code_msb |=> !ttl_ref_p && !ttl_ref_n)
    else $error("TTL reference active above code 7");
  a_ttl_pair: assert property ($past(ttl_en) |-> ttl_ref_p != ttl_ref_n)
    else $error("TTL pair not complementary");
  a_clear_zero: assert property (div_clear |=> chain == '0 && !ref_loop)
    else $error("synchronous clear left state");
  // Mux outputs are registered, so the gate shows one cycle after the code
  a_bad_code: assert property (!code_ok |=> !twice_hi && !twice_lo)
    else $error("invalid code left a mux enabled");
  // Invalid codes park every mux rather than guess an octave
  a_gate_off: assert property (!code_ok |-> sel_det == {ODTS_SEL_OFF, ODTS_SEL_OFF})
    else $error("invalid code left a detection mux enabled");
  a_cascade_link: assert property (code_ok && sel_det[7]
                    |-> sel_det[3:0] == {1'b1, ODTS_SEL_CHAIN})
    else $error("lower detection mux does not pass the upper one");
  a_twice_split: assert property (code_ok |-> sel_twice[7] || sel_twice[3])
    else $error("no twice-reference mux enabled on a valid code");
  a_ttl_invalid: assert property (!code_ok |=> !ttl_ref_p && !ttl_ref_n)
    else $error("TTL reference active on an invalid code");
  a_clear_taps: assert property (div_clear |=> !det_clk && !twice_ref_clk)
    else $error("synchronous clear left a selected clock high");

  c_harmonic: cover property (code_ok && harmonic_detect_select ##1 twice_rise);
  c_ttl_live: cover property (ttl_en ##1 ttl_ref_p ##[1:300] ttl_ref_n);
  c_top_range: cover property (code == ODTS_CODE_MAX && det_clk);
  c_soft_clear: cover property (wr_done ##1 div_clear);

endmodule : odts_divider

// ===== core/odts_pkg.sv
package odts_pkg;

  // Divider chain: bit e of the chain toggles at oscillator / 2^e
  localparam int ODTS_CHAIN_W = 18;
  localparam int ODTS_BIT_OSC = 0;
  localparam int ODTS_BIT_HALF1 = 1;
  localparam int ODTS_BIT_HALF2 = 2;
  localparam int ODTS_BIT_DIV8 = 5;
  localparam int ODTS_BIT_RIPPLE0 = 6;
  localparam int ODTS_BIT_LAST = 17;
  localparam int ODTS_BIT_CHOP = 5;
  localparam int ODTS_BIT_SAMPLE = 12;
  localparam int ODTS_BIT_FIX24K = 13;

  // Octave code and exponent arithmetic
  localparam logic [3:0] ODTS_CODE_MIN = 4'h2;
  localparam logic [3:0] ODTS_CODE_MAX = 4'he;
  localparam logic [4:0] ODTS_EXP_BASE = 5'h0e;
  localparam logic [4:0] ODTS_EXP_SPLIT = 5'h08;
  localparam logic [1:0] ODTS_ADD_TWICE = 2'h0;
  localparam logic [1:0] ODTS_ADD_DET = 2'h1;
  localparam logic [1:0] ODTS_ADD_REF = 2'h1;
  localparam logic [1:0] ODTS_ADD_2F = 2'h1;

  // Tap multiplexer select field
  localparam int ODTS_MUX_N = 8;
  localparam int ODTS_SEL_W = 3;
  localparam int ODTS_GATE_BIT = 3;
  localparam logic [3:0] ODTS_SEL_OFF = 4'h0;
  localparam logic [2:0] ODTS_SEL_CHAIN = 3'h7;

  // APB register map
  localparam int ODTS_ADDR_W = 12;
  localparam logic [11:0] ODTS_ADDR_CTRL = 12'h000;
  localparam logic [11:0] ODTS_ADDR_STATUS = 12'h004;
  localparam logic [11:0] ODTS_ADDR_COUNT = 12'h008;
  localparam int ODTS_CTRL_TTL_ALLOW = 0;
  localparam int ODTS_CTRL_DIV_CLEAR = 1;
  localparam logic ODTS_CTRL_TTL_RESET = 1'b1;
  localparam int ODTS_ST_CODE = 0;
  localparam int ODTS_ST_MODE = 4;
  localparam int ODTS_ST_VALID = 5;
  localparam int ODTS_ST_TTL = 6;
  localparam int ODTS_ST_REF = 7;
  localparam int ODTS_ST_TWICE = 8;
  localparam int ODTS_ST_DET = 9;

endpackage : odts_pkg

// ===== core/odts_tap_mux.sv
`timescale 1ns/100ps
module odts_tap_mux
  import odts_pkg::*;
#(
  parameter int N = ODTS_MUX_N,
  parameter int SW = ODTS_SEL_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic clear,
  // Taps and select field, top bit is the gate
  input wire logic [N-1:0] taps,
  input wire logic [SW:0] sel_field,
  // Selected tap, low while gated off
  output logic tap_out
);

  logic next_tap_out;

  always_comb begin
    next_tap_out = 1'b0;
    if (!clear && sel_field[SW]) begin
      next_tap_out = taps[sel_field[SW-1:0]];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tap_out <= 1'b0;
    end else begin
      tap_out <= next_tap_out;
    end
  end

endmodule : odts_tap_mux

// ===== test/odts_range_sel.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module odts_range_sel (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Requested range and mode
  input wire logic [3:0] code_req,
  input wire logic mode_req,
  // Loose code bits to the divider
  output logic octave_code_msb,
  output logic octave_code_b1,
  output logic octave_code_b2,
  output logic octave_code_lsb,
  output logic harmonic_detect_select
);
  // Registered, so all five bits move together just after an edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {octave_code_msb, octave_code_b1, octave_code_b2, octave_code_lsb} <= 4'h0;
      harmonic_detect_select <= 1'b0;
    end else begin
      {octave_code_msb, octave_code_b1, octave_code_b2, octave_code_lsb} <= code_req;
      harmonic_detect_select <= mode_req;
    end
  end
endmodule : odts_range_sel

// ===== test/testbench.sv
`timescale 1ns/100ps
module testbench;
  import odts_pkg::*;
  logic clock, rstn, psel, penable, pwrite, mode_req, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, last;
  logic [3:0] pstrb, code_req;
  logic det_clk, twice_ref_clk, ref_loop, ref_out, ttl_ref_p, ttl_ref_n;
  logic chop_sync_clk, fixed_24k_clk, sample_clk, b3, b1, b2, b0, hsel, v;
  logic [1:0] h;
  logic [5:0] watch;
  int failures, checks_done, p;

  assign watch = {fixed_24k_clk, sample_clk, chop_sync_clk, ref_out, twice_ref_clk, det_clk};

  ////////////////////////////////////////////////////////////////////////////////
  odts_range_sel u_odts_range_sel (.clock(clock), .rstn(rstn), .code_req(code_req),
    .mode_req(mode_req), .octave_code_msb(b3), .octave_code_b1(b1), .octave_code_b2(b2),
    .octave_code_lsb(b0), .harmonic_detect_select(hsel));

  odts_divider u_odts_divider (.clock(clock), .rstn(rstn), .octave_code_msb(b3),
    .octave_code_b1(b1), .octave_code_b2(b2), .octave_code_lsb(b0),
    .harmonic_detect_select(hsel), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .det_clk(det_clk), .twice_ref_clk(twice_ref_clk),
    .ref_loop(ref_loop), .ref_out(ref_out), .ttl_ref_p(ttl_ref_p), .ttl_ref_n(ttl_ref_n),
    .chop_sync_clk(chop_sync_clk), .fixed_24k_clk(fixed_24k_clk), .sample_clk(sample_clk));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // One APB transfer; the answer is taken only at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      give_verdict();
    end
  endtask : apb

  // Cycles between two rising edges of one watched clock
  task automatic period(input int k, output int pr);
    int n, start;
    logic prev, cur;
    start = -1;
    pr = 0;
    prev = 1'b1;
    for (n = 0; n < 40000 && pr == 0; n++) begin
      @(posedge clock);
      cur = watch[k];
      if (prev === 1'b0 && cur === 1'b1) begin
        if (start >= 0) pr = n - start;
        else start = n;
      end
      prev = cur;
    end
    if (pr == 0) begin
      failures++;
      give_verdict();
    end
  endtask : period

  // Mux outputs may glitch on a change, so let them settle
  task automatic set_code(input logic [3:0] c, input logic m);
    @(posedge clock);
    code_req <= c;
    mode_req <= m;
    repeat (8) @(posedge clock);
  endtask : set_code

  task automatic quiet(input int n);
    h = 2'h0;
    repeat (n) begin
      @(posedge clock);
      h = h | {det_clk | twice_ref_clk, ttl_ref_p | ttl_ref_n};
    end
  endtask : quiet

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, mode_req} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    code_req = 4'h0;
    failures = 0;
    checks_done = 0;
    rstn = 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    check({det_clk, twice_ref_clk, ref_out, ttl_ref_p, ttl_ref_n}, 32'h0);
    apb(1'b0, ODTS_ADDR_CTRL, 32'h0, 4'h0);
    check(rd, 32'h1);
    apb(1'b1, 12'h00c, 32'hffff_ffff, 4'hf);
    check(err, 1'b1);
    apb(1'b0, 12'h00c, 32'h0, 4'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, ODTS_ADDR_CTRL, 32'h0, 4'h0);
    apb(1'b1, ODTS_ADDR_STATUS, 32'hffff_ffff, 4'hf);
    check(err, 1'b0);
    apb(1'b0, ODTS_ADDR_CTRL, 32'h0, 4'h0);
    check(rd, 32'h1);
    // Soft clear, then two snapshots three cycles apart
    apb(1'b1, ODTS_ADDR_CTRL, 32'h3, 4'h1);
    apb(1'b0, ODTS_ADDR_COUNT, 32'h0, 4'h0);
    check(rd < 32'h10, 1'b1);
    last = rd;
    apb(1'b0, ODTS_ADDR_COUNT, 32'h0, 4'h0);
    check(rd - last, 32'h3);
    period(3, p);
    check(p, 64);
    period(4, p);
    check(p, 8192);
    period(5, p);
    check(p, 16384);
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 16; c++) begin
        set_code(c[3:0], m[0]);
        v = (c >= 2 && c <= 14);
        apb(1'b0, ODTS_ADDR_STATUS, 32'h0, 4'h0);
        check(rd & 32'h7f, {25'h0, v && c <= 7, v, m[0], c[3:0]});
        if (c >= 7 && c <= 14) begin
          period(0, p);
          check(p, 1 << (16 - c));
          period(1, p);
          check(p, 1 << (15 - c + m));
          period(2, p);
          check(p, 1 << (16 - c + m));
          check(ref_loop, ref_out);
        end else if (!v) begin
          quiet(64);
          check(h, 2'h0);
        end
      end
    end
    // Complementary pair trails the retimed reference by one cycle
    set_code(4'h7, 1'b0);
    @(posedge clock);
    last = ref_out;
    repeat (600) begin
      @(posedge clock);
      check(ttl_ref_n, {31'h0, ~ttl_ref_p});
      check(ttl_ref_p, last);
      last = ref_out;
    end
    apb(1'b1, ODTS_ADDR_CTRL, 32'h0, 4'h1);
    // The pair registered just before the write still stands for one edge
    @(posedge clock);
    quiet(600);
    check(h[0], 1'b0);
    apb(1'b1, ODTS_ADDR_CTRL, 32'h1, 4'h1);
    set_code(4'h8, 1'b0);
    quiet(600);
    check(h[0], 1'b0);
    give_verdict();
  end
endmodule : testbench
